// ==== verilog/jcp_pkg.sv ====
package jcp_pkg;

    // ********************************************************************
    // Register word indices and field positions.
    // ********************************************************************
    localparam logic       CHAR_PORT_IDX   = 1'b0;
    localparam logic       CTRL_IDX        = 1'b1;
    localparam int         DATA_LSB        = 0;
    localparam int         DATA_W          = 8;
    localparam int         RVALID_BIT      = 15;
    localparam int         COUNT_LSB       = 16;
    localparam int         COUNT_W         = 16;
    localparam int         RX_EN_BIT       = 0;
    localparam int         TX_EN_BIT       = 1;
    localparam int         RX_PEND_BIT     = 8;
    localparam int         TX_PEND_BIT     = 9;
    localparam int         POLL_SEEN_BIT   = 10;

    // ********************************************************************
    // Reset values and build-time defaults.
    // ********************************************************************
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
    localparam logic        EN_RESET       = 1'b0;
    localparam logic        POLL_RESET     = 1'b0;
    localparam int          RX_DEPTH_DEF   = 64;
    localparam int          TX_DEPTH_DEF   = 64;
    localparam int          RX_THRESH_DEF  = 8;
    localparam int          TX_THRESH_DEF  = 8;

endpackage

// ==== verilog/jcp_fifo_if.sv ====
`timescale 1ns/100ps

// Carries one FIFO's fill side, drain side and fill level.
interface jcp_fifo_if #(
    parameter int DW = 8,
    parameter int LW = 7
);
    logic          push_valid;
    logic [DW-1:0] push_data;
    logic          push_ready;
    logic          pop_valid;
    logic [DW-1:0] pop_data;
    logic          pop_ready;
    logic [LW-1:0] level;

    modport fifo (
        input  push_valid,
        input  push_data,
        output push_ready,
        output pop_valid,
        output pop_data,
        input  pop_ready,
        output level
    );

    modport user (
        output push_valid,
        output push_data,
        input  push_ready,
        input  pop_valid,
        input  pop_data,
        output pop_ready,
        input  level
    );
endinterface

// ==== verilog/jcp_fifo.sv ====
`timescale 1ns/100ps

// Synchronous FIFO; DEPTH must be a power of two so the pointers wrap freely.
module jcp_fifo #(
    parameter int DW    = 8,
    parameter int DEPTH = 64
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    jcp_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = AW + 1;

    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [LW-1:0] count;
    logic [LW-1:0] next_count;
    logic          ready_r;
    logic          valid_r;
    logic          push;
    logic          pop;

    // A push into a full FIFO is ignored here, which is how a full write side drops data.
    assign push       = f.push_valid && ready_r;
    assign pop        = f.pop_ready && valid_r;
    assign next_count = count + LW'(push) - LW'(pop);

    // Storage has no reset; pop_data shows mem[rd_ptr] even when the FIFO is empty.
    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            mem[wr_ptr] <= f.push_data;
        end
    end

    // Pointers, level and the registered full and empty flags.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            count   <= '0;
            ready_r <= 1'b0;
            valid_r <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count   <= next_count;
            ready_r <= (next_count != LW'(DEPTH));
            valid_r <= (next_count != '0);
        end
    end

    assign f.push_ready = ready_r;
    assign f.pop_valid  = valid_r;
    assign f.pop_data   = mem[rd_ptr];
    assign f.level      = count;
endmodule

// ==== verilog/jcp_regs.sv ====
// Overview of operation
// - Two 32-bit registers, word offsets zero and one.
// - Character read returns oldest byte and pops it.
// - Bit 15 marks returned character as valid.
// - Bits 31:16 report read FIFO level after read.
// - Character write pushes byte; full drops silently.
// - Bits 0 and 1 are interrupt enables.
// - Bits 8 and 9 show enabled interrupt conditions.
// - Bit 10 sets on host poll, stays set.
// - Writing one clears bit 10; zero keeps it.
// - Control bits 31:16 report write FIFO free space.
// - Control writes touch only enables and poll clear.
// - Interrupt output follows any enabled pending condition.
// - Write condition while write level at or below threshold.
// - Read condition while free entries at or below threshold.
// - Read condition also when data held, host idle.
`timescale 1ns/100ps

module jcp_regs #(
    parameter int RX_DEPTH  = jcp_pkg::RX_DEPTH_DEF,
    parameter int TX_DEPTH  = jcp_pkg::TX_DEPTH_DEF,
    parameter int RX_THRESH = jcp_pkg::RX_THRESH_DEF,
    parameter int TX_THRESH = jcp_pkg::TX_THRESH_DEF
) (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_addr,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_wdata,
    output logic      [31:0] o_rdata,
    output logic             o_rdata_valid,
    output logic             o_irq,
    input  wire logic        i_host_rx_valid,
    input  wire logic [7:0]  i_host_rx_data,
    output logic             o_host_rx_ready,
    output logic             o_host_tx_valid,
    output logic      [7:0]  o_host_tx_data,
    input  wire logic        i_host_tx_ready,
    input  wire logic        i_host_poll,
    input  wire logic        i_host_rx_idle
);
    localparam int RLW = $clog2(RX_DEPTH) + 1;
    localparam int TLW = $clog2(TX_DEPTH) + 1;

    // ********************************************************************
    // Reset release and FIFOs.
    // ********************************************************************
    logic rst_meta;
    logic rst_n;

    // Release is synchronised so no flop leaves reset on a partial edge.
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    jcp_fifo_if #(.DW(8), .LW(RLW)) rx_if ();
    jcp_fifo_if #(.DW(8), .LW(TLW)) tx_if ();

    jcp_fifo #(.DW(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .f       (rx_if.fifo)
    );

    jcp_fifo #(.DW(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .f       (tx_if.fifo)
    );

    // Word decode used by both read and write paths.
    function automatic logic hit(input logic addr, input logic idx);
        hit = (addr == idx);
    endfunction

    logic rd_char;
    logic wr_char;
    logic rd_ctrl;
    logic wr_ctrl;

    assign rd_char = i_read && hit(i_addr, jcp_pkg::CHAR_PORT_IDX);
    assign rd_ctrl = i_read && hit(i_addr, jcp_pkg::CTRL_IDX);
    assign wr_char = i_write && hit(i_addr, jcp_pkg::CHAR_PORT_IDX);
    assign wr_ctrl = i_write && hit(i_addr, jcp_pkg::CTRL_IDX);

    // Host side fills the read FIFO and drains the write FIFO.
    assign rx_if.push_valid = i_host_rx_valid;
    assign rx_if.push_data  = i_host_rx_data;
    assign tx_if.pop_ready  = i_host_tx_ready;
    assign o_host_rx_ready  = rx_if.push_ready;
    assign o_host_tx_valid  = tx_if.pop_valid;
    assign o_host_tx_data   = tx_if.pop_data;

    // Bus side pops on a character read and pushes on a character write.
    assign rx_if.pop_ready  = rd_char;
    assign tx_if.push_valid = wr_char;
    assign tx_if.push_data  = i_wdata[jcp_pkg::DATA_LSB +: jcp_pkg::DATA_W];

    // ********************************************************************
    // Control state and interrupt conditions.
    // ********************************************************************
    logic           rx_en;
    logic           tx_en;
    logic           poll_seen;
    logic           rx_cond;
    logic           tx_cond;
    logic           rx_pend;
    logic           tx_pend;
    logic [RLW-1:0] rx_free;
    logic [TLW-1:0] tx_free;

    assign rx_free = RLW'(RX_DEPTH) - rx_if.level;
    assign tx_free = TLW'(TX_DEPTH) - tx_if.level;
    assign tx_cond = (tx_if.level <= TLW'(TX_THRESH));
    assign rx_cond = (rx_free <= RLW'(RX_THRESH))
                  || (rx_if.pop_valid && i_host_rx_idle);
    assign rx_pend = rx_cond && rx_en;
    assign tx_pend = tx_cond && tx_en;

    // Only the enables store written values; bit 10 is cleared by writing one, other status fields ignore writes.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_en <= jcp_pkg::EN_RESET;
            tx_en <= jcp_pkg::EN_RESET;
        end
        else if (wr_ctrl)
        begin
            rx_en <= i_wdata[jcp_pkg::RX_EN_BIT];
            tx_en <= i_wdata[jcp_pkg::TX_EN_BIT];
        end
    end

    // A poll in the same cycle as a clear wins, so no host activity is missed.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            poll_seen <= jcp_pkg::POLL_RESET;
        end
        else if (i_host_poll)
        begin
            poll_seen <= 1'b1;
        end
        else if (wr_ctrl && i_wdata[jcp_pkg::POLL_SEEN_BIT])
        begin
            poll_seen <= 1'b0;
        end
    end

    // Interrupt output is registered, so it trails its cause by one cycle.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= rx_pend || tx_pend;
        end
    end

    // ********************************************************************
    // Read data path.
    // ********************************************************************
    logic [31:0] next_rdata;

    // Reserved bits read as zero; level is counted after this read's pop.
    always_comb
    begin
        next_rdata = '0;
        if (rd_char)
        begin
            next_rdata[jcp_pkg::DATA_LSB +: jcp_pkg::DATA_W] = rx_if.pop_data;
            next_rdata[jcp_pkg::RVALID_BIT] = rx_if.pop_valid;
            next_rdata[jcp_pkg::COUNT_LSB +: jcp_pkg::COUNT_W] =
                jcp_pkg::COUNT_W'(rx_if.level - RLW'(rx_if.pop_valid));
        end
        else if (rd_ctrl)
        begin
            next_rdata[jcp_pkg::RX_EN_BIT]     = rx_en;
            next_rdata[jcp_pkg::TX_EN_BIT]     = tx_en;
            next_rdata[jcp_pkg::RX_PEND_BIT]   = rx_pend;
            next_rdata[jcp_pkg::TX_PEND_BIT]   = tx_pend;
            next_rdata[jcp_pkg::POLL_SEEN_BIT] = poll_seen;
            next_rdata[jcp_pkg::COUNT_LSB +: jcp_pkg::COUNT_W] =
                jcp_pkg::COUNT_W'(tx_free);
        end
    end

    // Answer one cycle after the read strobe; data holds until the next read.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rdata       <= jcp_pkg::RDATA_RESET;
            o_rdata_valid <= 1'b0;
        end
        else
        begin
            o_rdata_valid <= i_read;
            if (i_read)
            begin
                o_rdata <= next_rdata;
            end
        end
    end

    // ********************************************************************
    // Assertions and covers.
    // ********************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    rd_pop_a: assert property (rd_char && rx_if.pop_valid |=>
        o_rdata_valid && o_rdata[7:0] == $past(rx_if.pop_data))
        else $error("Character read returned wrong byte.");
    rvalid_flag_a: assert property (rd_char |=>
        o_rdata[15] == $past(rx_if.pop_valid))
        else $error("Valid bit does not match read FIFO state.");
    rx_level_a: assert property (rd_char && rx_if.pop_valid |=>
        o_rdata[31:16] == 16'($past(rx_if.level) - 1) &&
        ($past(rx_if.push_valid && rx_if.push_ready) || o_rdata[31:16] == 16'(rx_if.level)))
        else $error("Reported read level is not level after pop.");
    tx_drop_a: assert property (wr_char && !tx_if.push_ready && !tx_if.pop_ready |=>
        tx_if.level == $past(tx_if.level))
        else $error("Write to full FIFO changed its level.");
    enable_wr_a: assert property (wr_ctrl ##1 !wr_ctrl[*2] |->
        {tx_en, rx_en} == $past(i_wdata[1:0], 2))
        else $error("Enables do not hold written value.");
    pend_read_a: assert property (rd_ctrl |=>
        o_rdata[9:8] == $past({tx_cond & tx_en, rx_cond & rx_en}))
        else $error("Pending bits not condition and enable.");
    poll_set_a: assert property (i_host_poll |=> poll_seen [*2] or
        (poll_seen ##1 $past(wr_ctrl && i_wdata[10])))
        else $error("Poll flag did not set and hold.");
    poll_clear_a: assert property (wr_ctrl && i_wdata[10] && !i_host_poll |=> !poll_seen)
        else $error("Writing one did not clear poll flag.");
    free_a: assert property (rd_ctrl |=>
        o_rdata[31:16] == 16'(TX_DEPTH) - 16'($past(tx_if.level)))
        else $error("Free space field wrong.");
    irq_out_a: assert property ((rx_pend || tx_pend) |=> o_irq ##0
        $past(rx_cond && rx_en || tx_cond && tx_en))
        else $error("Interrupt output does not follow pending state.");

    valid_read_c: cover property (rd_char && rx_if.pop_valid);
    drop_write_c: cover property (wr_char && !tx_if.push_ready);
    poll_clear_c: cover property (poll_seen ##1 wr_ctrl && i_wdata[10] ##1 !poll_seen);
    irq_rise_c:   cover property (!o_irq ##1 o_irq);
endmodule

// ==== tb/jcp_host_model.sv ====
`timescale 1ns/100ps

// Host side of the character link: feeds the read FIFO and drains the write FIFO.
module jcp_host_model (
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    output logic            o_rx_valid,
    output logic      [7:0] o_rx_data,
    input  wire logic       i_rx_ready,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_poll,
    output logic            o_rx_idle
);
    logic [7:0] send_q[$];
    logic [7:0] got_q[$];
    logic       tx_take = 1'b1;
    logic       idle = 1'b0;

    initial
    begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
        o_tx_ready = 1'b0;
        o_poll     = 1'b0;
    end

    assign o_rx_idle = idle;

    // Handshakes resolve on the edge; the new offer lands a little later.
    // A released data line toggles so no stale byte can pass for a real one.
    always @(posedge i_clock)
    begin
        if (i_nrst && o_rx_valid && i_rx_ready)
            void'(send_q.pop_front());
        if (i_nrst && o_tx_ready && i_tx_valid)
            got_q.push_back(i_tx_data);
        #5;
        o_tx_ready = tx_take;
        if (send_q.size() > 0)
        begin
            o_rx_valid = 1'b1;
            o_rx_data  = send_q[0];
        end
        else
        begin
            o_rx_valid = 1'b0;
            o_rx_data  = ~o_rx_data;
        end
    end

    // A poll is a single pulse; real hosts may leave seconds between them.
    task automatic poll();
        @(posedge i_clock);
        #5 o_poll = 1'b1;
        @(posedge i_clock);
        #5 o_poll = 1'b0;
    endtask
endmodule

// ==== tb/test_jtag_char_port_registers.sv ====
`timescale 1ns/100ps

module test_jtag_char_port_registers;
    logic        i_clock = 1'b0;
    logic        i_nrst  = 1'b0;
    logic        i_addr  = 1'b0;
    logic        i_read  = 1'b0;
    logic        i_write = 1'b0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [31:0] o_rdata;
    logic        o_rdata_valid;
    logic        o_irq;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_ready;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ready;
    logic        poll;
    logic        rx_idle;
    logic [31:0] rdv;
    int          n_fail = 0;
    int          check_count = 0;

    jcp_regs jcp_regs_i (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_read(i_read),
        .i_write(i_write), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rdata_valid(o_rdata_valid), .o_irq(o_irq), .i_host_rx_valid(rx_valid),
        .i_host_rx_data(rx_data), .o_host_rx_ready(rx_ready),
        .o_host_tx_valid(tx_valid), .o_host_tx_data(tx_data),
        .i_host_tx_ready(tx_ready), .i_host_poll(poll), .i_host_rx_idle(rx_idle));

    jcp_host_model jcp_host_model_i (
        .i_clock(i_clock), .i_nrst(i_nrst), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_ready(tx_ready), .o_poll(poll), .o_rx_idle(rx_idle));

    // ********************************************************************
    // Clock, verdict and bus helpers.
    // ********************************************************************
    initial
    begin
        forever #25 i_clock = ~i_clock;
    end

    task automatic results();
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (exp !== got)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Read data is registered, so it is taken one cycle after the strobe.
    task automatic rd(input logic a);
        @(posedge i_clock);
        #5 i_addr = a;
        i_read = 1'b1;
        @(posedge i_clock);
        #5 i_read = 1'b0;
        chk("rdata_valid", 32'h1, {31'h0, o_rdata_valid});
        rdv = o_rdata;
    endtask

    // Reserved bits are always written as zero by the callers.
    task automatic wr(input logic a, input logic [31:0] d);
        @(posedge i_clock);
        #5 i_addr = a;
        i_write = 1'b1;
        i_wdata = d;
        @(posedge i_clock);
        #5 i_write = 1'b0;
    endtask

    task automatic drain_tx(input int n);
        for (int k = 0; k < 300 && jcp_host_model_i.got_q.size() < n; k++)
            @(posedge i_clock);
        chk("tx_count", n, jcp_host_model_i.got_q.size());
    endtask

    // ********************************************************************
    // Scenarios.
    // ********************************************************************
    task automatic t_reset();
        rd(1'b1);
        chk("ctrl_reset", 32'h0040_0000, rdv);
        rd(1'b0);
        chk("char_empty", 32'h0, {15'h0, rdv[31:15]});
        chk("rx_ready_idle", 32'h1, {31'h0, rx_ready});
        chk("tx_valid_idle", 32'h0, {31'h0, tx_valid});
    endtask

    task automatic t_rx();
        for (int i = 0; i < 3; i++)
            jcp_host_model_i.send_q.push_back(8'ha1 + 8'(i));
        repeat (6) @(posedge i_clock);
        for (int i = 0; i < 3; i++)
        begin
            rd(1'b0);
            chk("char_read", {16'(2 - i), 8'h80, 8'ha1 + 8'(i)}, rdv);
        end
    endtask

    // The host stalls so the write FIFO fills; the 65th byte must vanish.
    task automatic t_tx();
        jcp_host_model_i.tx_take = 1'b0;
        for (int i = 0; i < 65; i++)
            wr(1'b0, {24'h0, 8'(i)});
        rd(1'b1);
        chk("tx_free_full", 32'h0, {16'h0, rdv[31:16]});
        jcp_host_model_i.tx_take = 1'b1;
        drain_tx(64);
        repeat (10) @(posedge i_clock);
        for (int i = 0; i < 64; i++)
            chk("tx_byte", i, jcp_host_model_i.got_q[i]);
        chk("tx_dropped", 64, jcp_host_model_i.got_q.size());
        jcp_host_model_i.got_q.delete();
    endtask

    task automatic t_irq();
        wr(1'b1, 32'h2);
        repeat (3) @(posedge i_clock);
        #5;
        chk("irq_tx", 32'h1, {31'h0, o_irq});
        rd(1'b1);
        chk("ctrl_tx_pend", 32'h0040_0202, rdv);
        jcp_host_model_i.tx_take = 1'b0;
        for (int i = 0; i < 9; i++)
            wr(1'b0, 32'h55);
        rd(1'b1);
        chk("ctrl_tx_above", 32'h0037_0002, rdv);
        chk("irq_off", 32'h0, {31'h0, o_irq});
        jcp_host_model_i.tx_take = 1'b1;
        drain_tx(9);
        jcp_host_model_i.got_q.delete();
        wr(1'b1, 32'h1);
        jcp_host_model_i.idle = 1'b1;
        jcp_host_model_i.send_q.push_back(8'h3c);
        repeat (6) @(posedge i_clock);
        #5;
        chk("irq_rx_idle", 32'h1, {31'h0, o_irq});
        rd(1'b0);
        repeat (3) @(posedge i_clock);
        #5;
        chk("irq_rx_clear", 32'h0, {31'h0, o_irq});
        jcp_host_model_i.idle = 1'b0;
        for (int i = 0; i < 55; i++)
            jcp_host_model_i.send_q.push_back(8'(i));
        repeat (60) @(posedge i_clock);
        rd(1'b1);
        chk("ctrl_rx_free9", 32'h0040_0001, rdv);
        jcp_host_model_i.send_q.push_back(8'h77);
        repeat (5) @(posedge i_clock);
        rd(1'b1);
        chk("ctrl_rx_free8", 32'h0040_0101, rdv);
        for (int i = 0; i < 56; i++)
            rd(1'b0);
        chk("rx_last", 32'h0000_8077, rdv);
        wr(1'b1, 32'h0);
    endtask

    task automatic t_poll();
        jcp_host_model_i.poll();
        repeat (2) @(posedge i_clock);
        rd(1'b1);
        chk("poll_set", 32'h0040_0400, rdv);
        wr(1'b1, 32'h0000_0300);
        rd(1'b1);
        chk("ctrl_ro_bits", 32'h0040_0400, rdv);
        wr(1'b1, 32'h0000_0400);
        rd(1'b1);
        chk("poll_clear", 32'h0040_0000, rdv);
        // A poll landing on the same edge as a clear must keep the flag set.
        fork
            jcp_host_model_i.poll();
            wr(1'b1, 32'h0000_0400);
        join
        rd(1'b1);
        chk("poll_wins", 32'h0040_0400, rdv);
    endtask

    // Main sequence: reset held for twelve cycles, then each scenario in turn.
    initial
    begin
        repeat (12) @(posedge i_clock);
        #5 i_nrst = 1'b1;
        repeat (6) @(posedge i_clock);
        t_reset();
        t_rx();
        t_tx();
        t_irq();
        t_poll();
        results();
    end

    // The whole run needs about 500 cycles; this limit leaves ample margin.
    initial
    begin
        #1_000_000;
        n_fail++;
        results();
    end
endmodule
